//--- logic/vmon_pkg.sv
// package for the channel-one supply monitor control block
// assumes an axi4-lite master and a 20 mhz system clock
package vmon_pkg;
   // ----------------------------------------------------------
   // register offsets (byte addresses)
   // ----------------------------------------------------------
   localparam logic [7:0] LEVEL_SELECT_REG_OFS = 8'h00;
   localparam logic [7:0] COMPARATOR_CONTROL_REG_OFS = 8'h04;
   localparam logic [7:0] CONTROL_A_OFS = 8'h08;
   localparam logic [7:0] CONTROL_B_OFS = 8'h0c;
   localparam logic [7:0] STATUS_OFS = 8'h10;
   // ----------------------------------------------------------
   // field positions
   // ----------------------------------------------------------
   localparam int LEVEL_LSB = 0;            // level_select_one[3:0]
   localparam int CIRCUIT_EN_BIT = 0;       // detect_circuit_enable_one
   localparam int RIE_BIT = 0;              // irq_reset_enable
   localparam int FILTER_DIS_BIT = 1;       // filter_disable_bit
   localparam int CMPE_BIT = 2;             // compare_output_enable
   localparam int RI_BIT = 3;               // irq_or_reset_select
   localparam int RN_BIT = 4;               // reset_negation_type
   localparam int FSAMP_LSB = 5;            // filter_sample_divisor
   localparam int EDGE_LSB = 0;             // request_edge_select
   localparam int NMI_BIT = 2;              // nmi_or_maskable_select
   localparam int DET_BIT = 0;              // crossing_detected_flag
   localparam int MON_BIT = 1;              // level_monitor_flag
   // ----------------------------------------------------------
   // reset values
   // ----------------------------------------------------------
   localparam logic [3:0] LEVEL_RST = 4'h0;
   localparam logic [6:0] CONTROL_A_RST = 7'h02; // filter off
   localparam logic [2:0] CONTROL_B_RST = 3'h1;  // falling edge
   // ----------------------------------------------------------
   // edge select codes
   // ----------------------------------------------------------
   localparam logic [1:0] EDGE_RISE = 2'h0;
   localparam logic [1:0] EDGE_FALL = 2'h1;
   localparam logic [1:0] EDGE_BOTH = 2'h2;
   // ----------------------------------------------------------
   // axi responses
   // ----------------------------------------------------------
   localparam logic [1:0] RESP_OKAY = 2'h0;
   localparam logic [1:0] RESP_SLVERR = 2'h2;
   // ----------------------------------------------------------
   // carriers
   // ----------------------------------------------------------
   typedef struct packed {
      logic nmi_sel;         // nmi_or_maskable_select, bit 2
      logic [1:0] edge_sel;  // request_edge_select, bits 1:0
   } vmon_ctlb_type;
   typedef struct packed {
      logic [1:0] fsamp;     // filter_sample_divisor
      logic rn;              // reset_negation_type
      logic ri;              // irq_or_reset_select
      logic cmpe;            // compare_output_enable
      logic fdis;            // filter_disable_bit
      logic rie;             // irq_reset_enable
   } vmon_ctla_type;
   typedef enum logic [2:0] {
      VMON_IDLE = 3'b001,
      VMON_WRESP = 3'b010,
      VMON_RRESP = 3'b100
   } vmon_bus_state_type;
endpackage : vmon_pkg

//--- logic/vmon_filter.sv
// digital noise filter for the comparator level
// assumes comp_in is already synchronised and osc_tick_in is a
// one-cycle pulse per low-speed oscillator cycle
`timescale 1ns/1ns
module vmon_filter
(
   input wire logic clock_in,
   input wire logic rst_b_in,
   input wire logic osc_tick_in,     // one low-speed osc cycle
   input wire logic [1:0] fsamp_in,  // divisor select n=2,4,8,16
   input wire logic enable_in,       // filter on
   input wire logic comp_in,         // raw comparator level
   output logic level_out            // accepted level
);
   // ----------------------------------------------------------
   // state
   // ----------------------------------------------------------
   typedef struct packed {
      logic [3:0] div;   // osc cycle count within sample period
      logic s1;          // newest sample
      logic level;       // accepted level
   } vmon_filt_type;
   vmon_filt_type st_ff, nxt_st;

   // divisor minus one from the two-bit select
   function automatic logic [3:0] div_last(input logic [1:0] sel);
      div_last = 4'((5'h02 << sel) - 5'h01);
   endfunction : div_last

   // ----------------------------------------------------------
   // sample every n osc cycles, accept after two equal samples
   // ----------------------------------------------------------
   always_comb
   begin
      nxt_st = st_ff;
      if (!enable_in)
      begin
         // bypass keeps samples primed to avoid a stale glitch
         nxt_st.div = 4'h0;
         nxt_st.s1 = comp_in;
         nxt_st.level = comp_in;
      end
      else if (osc_tick_in)
      begin
         if (st_ff.div >= div_last(fsamp_in))
         begin
            nxt_st.div = 4'h0;
            nxt_st.s1 = comp_in;
            if (st_ff.s1 == comp_in)
               nxt_st.level = comp_in;
         end
         else
            nxt_st.div = st_ff.div + 4'h1;
      end
   end

   // registered state
   always_ff @(posedge clock_in or negedge rst_b_in)
   begin
      if (!rst_b_in)
         st_ff <= '0;
      else
         st_ff <= nxt_st;
   end

   assign level_out = st_ff.level;
endmodule : vmon_filter

//--- logic/vmon_top.sv
// control logic of the channel-one supply monitor
// assumes axi4-lite master, analog comparator output on a pin
// Function
// - sampling clock is oscillator divided by n
// - writing zero to disable bit enables filter
// - select bit zero chooses interrupt
// - honour edge select and nmi select
// - writing zero clears detection flag
// - enable bit lets crossing raise request
// - forward comparison only while output enabled
// - select bit one chooses reset, negation type
// - writing one to disable bit stops filter
// - set flag on crossing, give monitor flag
// - filter accepts level stable two samples
//
// Design decisions made here: the address map and the AXI4-Lite slave port.
`timescale 1ns/1ns
module vmon_top
#(
   parameter int OSC_DIV = 160  // system cycles per osc cycle
)
(
   input wire logic clock_in,
   input wire logic rst_b_in,
   input wire logic comp_in,           // comparator: 1 = above
   input wire logic [7:0] s_axi_awaddr,
   input wire logic s_axi_awvalid,
   output logic s_axi_awready,
   input wire logic [31:0] s_axi_wdata,
   input wire logic [3:0] s_axi_wstrb,
   input wire logic s_axi_wvalid,
   output logic s_axi_wready,
   output logic [1:0] s_axi_bresp,
   output logic s_axi_bvalid,
   input wire logic s_axi_bready,
   input wire logic [7:0] s_axi_araddr,
   input wire logic s_axi_arvalid,
   output logic s_axi_arready,
   output logic [31:0] s_axi_rdata,
   output logic [1:0] s_axi_rresp,
   output logic s_axi_rvalid,
   input wire logic s_axi_rready,
   output logic [3:0] level_select_one_out,
   output logic detect_enable_out,      // analog circuit enable
   output logic nmi_out,                // one-cycle pulse
   output logic maskable_irq_out,       // one-cycle pulse
   output logic monitor_reset_out,      // level
   output logic reset_negation_type_out
);
   // ----------------------------------------------------------
   // state
   // ----------------------------------------------------------
   typedef struct packed {
      vmon_pkg::vmon_bus_state_type bus;
      logic aw_got;
      logic w_got;
      logic [7:0] awaddr;
      logic [31:0] wdata;
      logic [3:0] wstrb;
      logic [1:0] bresp;
      logic [31:0] rdata;
      logic [1:0] rresp;
      logic [3:0] level;
      logic circuit_en;
      vmon_pkg::vmon_ctla_type ctla;
      vmon_pkg::vmon_ctlb_type ctlb;
      logic det;
      logic prev_lvl;
      logic [1:0] sync;
      logic [7:0] osc_cnt;
      logic nmi;
      logic irq;
      logic rst_req;
   } vmon_state_type;
   vmon_state_type st_ff, nxt_st;
   logic filt_lvl;       // filter output
   logic cur_lvl;        // level after filter/bypass choice
   logic osc_tick;       // low-speed oscillator enable pulse
   logic rise, fall, hit;

   // ----------------------------------------------------------
   // helpers
   // ----------------------------------------------------------
   function automatic logic is_addr(input logic [7:0] a,
                                    input logic [7:0] ofs);
      is_addr = (a[7:2] == ofs[7:2]);
   endfunction : is_addr

   assign osc_tick = (st_ff.osc_cnt == 8'(OSC_DIV - 1));

   // ----------------------------------------------------------
   // filter instance
   // ----------------------------------------------------------
   vmon_filter u_filter
   (
      .clock_in(clock_in),
      .rst_b_in(rst_b_in),
      .osc_tick_in(osc_tick),
      .fsamp_in(st_ff.ctla.fsamp),
      .enable_in(!st_ff.ctla.fdis),
      .comp_in(st_ff.sync[1]),
      .level_out(filt_lvl)
   );

   // raw level when filter is off, filtered level otherwise
   assign cur_lvl = st_ff.ctla.fdis ? st_ff.sync[1] : filt_lvl;
   assign rise = cur_lvl && !st_ff.prev_lvl;
   assign fall = !cur_lvl && st_ff.prev_lvl;
   // crossing kind chosen by the edge select code; code 3 matches nothing
   always_comb
   begin
      case (st_ff.ctlb.edge_sel)
         vmon_pkg::EDGE_RISE: hit = rise;
         vmon_pkg::EDGE_FALL: hit = fall;
         vmon_pkg::EDGE_BOTH: hit = rise || fall;
         default: hit = 1'b0;
      endcase
   end

   // ----------------------------------------------------------
   // next state
   // ----------------------------------------------------------
   always_comb
   begin
      logic wr_fire;
      logic det_clr;
      logic qual;
      logic [31:0] wd;
      wr_fire = 1'b0;
      det_clr = 1'b0;
      qual = 1'b0;
      wd = st_ff.wdata;
      nxt_st = st_ff;
      nxt_st.sync = {st_ff.sync[0], comp_in};
      nxt_st.osc_cnt = osc_tick ? 8'h00 : st_ff.osc_cnt + 8'h01;
      nxt_st.nmi = 1'b0;
      nxt_st.irq = 1'b0;
      nxt_st.prev_lvl = cur_lvl;
      // bus handshake
      case (st_ff.bus)
         vmon_pkg::VMON_IDLE:
         begin
            if (s_axi_awvalid && !st_ff.aw_got)
            begin
               nxt_st.aw_got = 1'b1;
               nxt_st.awaddr = s_axi_awaddr;
            end
            if (s_axi_wvalid && !st_ff.w_got)
            begin
               nxt_st.w_got = 1'b1;
               nxt_st.wdata = s_axi_wdata;
               nxt_st.wstrb = s_axi_wstrb;
            end
            if (st_ff.aw_got && st_ff.w_got)
            begin
               wr_fire = 1'b1;
               nxt_st.aw_got = 1'b0;
               nxt_st.w_got = 1'b0;
               nxt_st.bus = vmon_pkg::VMON_WRESP;
            end
            else if (s_axi_arvalid)
            begin
               nxt_st.bus = vmon_pkg::VMON_RRESP;
               nxt_st.rresp = vmon_pkg::RESP_OKAY;
               nxt_st.rdata = 32'h0;
               if (is_addr(s_axi_araddr, vmon_pkg::LEVEL_SELECT_REG_OFS))
                  nxt_st.rdata[3:0] = st_ff.level;
               else if (is_addr(s_axi_araddr,
                                vmon_pkg::COMPARATOR_CONTROL_REG_OFS))
                  nxt_st.rdata[0] = st_ff.circuit_en;
               else if (is_addr(s_axi_araddr, vmon_pkg::CONTROL_A_OFS))
                  nxt_st.rdata[6:0] = st_ff.ctla;
               else if (is_addr(s_axi_araddr, vmon_pkg::CONTROL_B_OFS))
                  nxt_st.rdata[2:0] = st_ff.ctlb;
               else if (is_addr(s_axi_araddr, vmon_pkg::STATUS_OFS))
               begin
                  nxt_st.rdata[vmon_pkg::DET_BIT] = st_ff.det;
                  nxt_st.rdata[vmon_pkg::MON_BIT] = cur_lvl;
               end
               else
                  nxt_st.rresp = vmon_pkg::RESP_SLVERR;
            end
         end
         vmon_pkg::VMON_WRESP:
            if (s_axi_bready)
               nxt_st.bus = vmon_pkg::VMON_IDLE;
         vmon_pkg::VMON_RRESP:
            if (s_axi_rready)
               nxt_st.bus = vmon_pkg::VMON_IDLE;
         default:
            nxt_st.bus = vmon_pkg::VMON_IDLE;
      endcase
      // register writes, only byte lane 0 carries fields
      if (wr_fire)
      begin
         nxt_st.bresp = vmon_pkg::RESP_OKAY;
         if (!st_ff.wstrb[0])
            ;  // no lane, nothing stored
         else if (is_addr(st_ff.awaddr, vmon_pkg::LEVEL_SELECT_REG_OFS))
            nxt_st.level = wd[3:0];
         else if (is_addr(st_ff.awaddr,
                          vmon_pkg::COMPARATOR_CONTROL_REG_OFS))
            nxt_st.circuit_en = wd[vmon_pkg::CIRCUIT_EN_BIT];
         else if (is_addr(st_ff.awaddr, vmon_pkg::CONTROL_A_OFS))
            nxt_st.ctla = wd[6:0];
         else if (is_addr(st_ff.awaddr, vmon_pkg::CONTROL_B_OFS))
            nxt_st.ctlb = wd[2:0];
         else if (is_addr(st_ff.awaddr, vmon_pkg::STATUS_OFS))
            det_clr = !wd[vmon_pkg::DET_BIT];
         else
            nxt_st.bresp = vmon_pkg::RESP_SLVERR;
      end
      // detection: set wins over a clear in the same cycle
      qual = st_ff.circuit_en && st_ff.ctla.cmpe && hit;
      if (qual)
         nxt_st.det = 1'b1;
      else if (det_clr)
         nxt_st.det = 1'b0;
      // request only on a fresh qualifying crossing
      if (qual && st_ff.ctla.rie)
      begin
         if (st_ff.ctla.ri)
            nxt_st.rst_req = 1'b1;
         else if (st_ff.ctlb.nmi_sel)
            nxt_st.nmi = 1'b1;
         else
            nxt_st.irq = 1'b1;
      end
      // reset negates while the level is above or when reset operation is left;
      // negation type 0 waits for recovery, 1 releases at once
      if (st_ff.rst_req && (!st_ff.ctla.ri || !st_ff.ctla.rie ||
          st_ff.ctla.rn || cur_lvl))
         nxt_st.rst_req = 1'b0;
   end

   // registered state
   always_ff @(posedge clock_in or negedge rst_b_in)
   begin
      if (!rst_b_in)
      begin
         st_ff <= '0;
         st_ff.bus <= vmon_pkg::VMON_IDLE;
         st_ff.level <= vmon_pkg::LEVEL_RST;
         st_ff.ctla <= vmon_pkg::CONTROL_A_RST;
         st_ff.ctlb <= vmon_pkg::CONTROL_B_RST;
         st_ff.prev_lvl <= 1'b1;
         st_ff.sync <= 2'b11;  // idle above threshold, no false edge
      end
      else
         st_ff <= nxt_st;
   end

   // ----------------------------------------------------------
   // outputs
   // ----------------------------------------------------------
   assign s_axi_awready = (st_ff.bus == vmon_pkg::VMON_IDLE) &&
                          !st_ff.aw_got;
   assign s_axi_wready = (st_ff.bus == vmon_pkg::VMON_IDLE) &&
                         !st_ff.w_got;
   assign s_axi_arready = (st_ff.bus == vmon_pkg::VMON_IDLE) &&
                          !(st_ff.aw_got && st_ff.w_got);
   assign s_axi_bvalid = (st_ff.bus == vmon_pkg::VMON_WRESP);
   assign s_axi_bresp = st_ff.bresp;
   assign s_axi_rvalid = (st_ff.bus == vmon_pkg::VMON_RRESP);
   assign s_axi_rdata = st_ff.rdata;
   assign s_axi_rresp = st_ff.rresp;
   assign level_select_one_out = st_ff.level;
   assign detect_enable_out = st_ff.circuit_en;
   assign nmi_out = st_ff.nmi;
   assign maskable_irq_out = st_ff.irq;
   assign monitor_reset_out = st_ff.rst_req;
   assign reset_negation_type_out = st_ff.ctla.rn;
endmodule : vmon_top

//--- verification/vmon_top_assertions.sv
// checker for the channel-one monitor control block
// assumes it is bound into vmon_top and sees only its ports
`timescale 1ns/1ns
module vmon_checker
#(
   parameter int OSC_DIV = 160  // kept in step with the design
)
(
   input wire logic clock_in,
   input wire logic rst_b_in,
   input wire logic s_axi_awvalid,
   input wire logic s_axi_awready,
   input wire logic s_axi_wvalid,
   input wire logic s_axi_wready,
   input wire logic [1:0] s_axi_bresp,
   input wire logic s_axi_bvalid,
   input wire logic s_axi_bready,
   input wire logic s_axi_arvalid,
   input wire logic s_axi_arready,
   input wire logic [31:0] s_axi_rdata,
   input wire logic s_axi_rvalid,
   input wire logic s_axi_rready,
   input wire logic [3:0] level_select_one_out,
   input wire logic detect_enable_out,
   input wire logic nmi_out,
   input wire logic maskable_irq_out,
   input wire logic monitor_reset_out
);
   default clocking @(posedge clock_in); endclocking
   default disable iff (!rst_b_in);
   // ----------------------------------------------------------
   // bus handshake
   // ----------------------------------------------------------
   // answers must stand until the master takes them
   bresp_hold_a: assert property (s_axi_bvalid && !s_axi_bready
      |=> s_axi_bvalid && $stable(s_axi_bresp))
      else $error("write response dropped early");
   rdata_hold_a: assert property (s_axi_rvalid && !s_axi_rready
      |=> s_axi_rvalid && $stable(s_axi_rdata))
      else $error("read data dropped early");
   // a full write must be answered within two cycles
   write_answer_a: assert property (s_axi_awvalid && s_axi_awready
      && s_axi_wvalid && s_axi_wready |-> ##[1:2] s_axi_bvalid)
      else $error("write not answered");
   // no new request taken while a response is out
   busy_refuse_a: assert property (s_axi_bvalid || s_axi_rvalid
      |-> !s_axi_arready && !s_axi_awready)
      else $error("request taken while busy");
   // ----------------------------------------------------------
   // control outputs
   // ----------------------------------------------------------
   level_write_a: assert property ($changed(level_select_one_out)
      |-> s_axi_bvalid || $past(s_axi_bvalid))
      else $error("level changed without a write");
   enable_write_a: assert property ($changed(detect_enable_out)
      |-> s_axi_bvalid || $past(s_axi_bvalid))
      else $error("circuit enable changed without a write");
   nmi_pulse_a: assert property (nmi_out |=> !nmi_out)
      else $error("nmi longer than one cycle");
   irq_pulse_a: assert property (maskable_irq_out
      |=> !maskable_irq_out)
      else $error("irq longer than one cycle");
   one_kind_a: assert property (!(nmi_out && maskable_irq_out))
      else $error("both interrupt kinds at once");
   reset_no_irq_a: assert property (monitor_reset_out
      |-> !nmi_out && !maskable_irq_out)
      else $error("interrupt raised in reset mode");
   // main scenarios reached
   nmi_seen_c: cover property (nmi_out);
   irq_seen_c: cover property (maskable_irq_out);
   reset_seen_c: cover property ($rose(monitor_reset_out));
   read_seen_c: cover property (s_axi_rvalid && s_axi_rready);
endmodule : vmon_checker

bind vmon_top vmon_checker #(.OSC_DIV(OSC_DIV)) u_vmon_chk
(
   .clock_in, .rst_b_in, .s_axi_awvalid, .s_axi_awready, .s_axi_wvalid,
   .s_axi_wready, .s_axi_bresp, .s_axi_bvalid, .s_axi_bready,
   .s_axi_arvalid, .s_axi_arready, .s_axi_rdata, .s_axi_rvalid,
   .s_axi_rready, .level_select_one_out, .detect_enable_out, .nmi_out,
   .maskable_irq_out, .monitor_reset_out
);

//--- verification/tb_vmon_top.sv
// self-checking bench for the channel-one monitor control block
// assumes the package and design files are compiled first
`timescale 1ns/1ns
module tb_vmon_top;
   localparam int DIV = 4;  // short osc tick keeps filter waits small
   localparam logic [7:0] LV = vmon_pkg::LEVEL_SELECT_REG_OFS;
   localparam logic [7:0] CE = vmon_pkg::COMPARATOR_CONTROL_REG_OFS;
   localparam logic [7:0] CA = vmon_pkg::CONTROL_A_OFS;
   localparam logic [7:0] CB = vmon_pkg::CONTROL_B_OFS;
   localparam logic [7:0] ST = vmon_pkg::STATUS_OFS;
   localparam logic [1:0] OK = vmon_pkg::RESP_OKAY;
   localparam logic [1:0] ERR = vmon_pkg::RESP_SLVERR;
   localparam int EXP[4] = '{1, 1, 2, 0};  // requests per edge code
   logic clock_in, rst_b_in, comp_in;
   logic [7:0] s_axi_awaddr, s_axi_araddr;
   logic s_axi_awvalid, s_axi_awready, s_axi_wvalid, s_axi_wready;
   logic [31:0] s_axi_wdata, s_axi_rdata;
   logic [3:0] s_axi_wstrb, level_select_one_out;
   logic [1:0] s_axi_bresp, s_axi_rresp;
   logic s_axi_bvalid, s_axi_bready, s_axi_arvalid, s_axi_arready;
   logic s_axi_rvalid, s_axi_rready, detect_enable_out, nmi_out;
   logic maskable_irq_out, monitor_reset_out, reset_negation_type_out;
   int n_errors = 0, n_tests = 0, n_nmi = 0, n_irq = 0, b_n = 0, b_i = 0;

   vmon_top #(.OSC_DIV(DIV)) DUT
   (
      .clock_in, .rst_b_in, .comp_in, .s_axi_awaddr, .s_axi_awvalid,
      .s_axi_awready, .s_axi_wdata, .s_axi_wstrb, .s_axi_wvalid,
      .s_axi_wready, .s_axi_bresp, .s_axi_bvalid, .s_axi_bready,
      .s_axi_araddr, .s_axi_arvalid, .s_axi_arready, .s_axi_rdata,
      .s_axi_rresp, .s_axi_rvalid, .s_axi_rready, .level_select_one_out,
      .detect_enable_out, .nmi_out, .maskable_irq_out, .monitor_reset_out,
      .reset_negation_type_out
   );
   // ----------------------------------------------------------
   // clock and request counters
   // ----------------------------------------------------------
   initial
   begin
      clock_in = 1'b0;
      forever #25 clock_in = ~clock_in;
   end
   // pulses are counted, so a stuck or doubled request shows up
   always @(posedge clock_in)
   begin
      n_nmi <= n_nmi + int'(nmi_out === 1'b1);
      n_irq <= n_irq + int'(maskable_irq_out === 1'b1);
   end
   // ----------------------------------------------------------
   // shared tasks
   // ----------------------------------------------------------
   task check(input logic [31:0] seen, input logic [31:0] exp,
              input string msg);
      n_tests++;
      if (seen !== exp)
      begin
         n_errors++;
         $display("CHECK FAILED %0t %s", $time, msg);
      end
   endtask : check
   // bus write: aw and w released one by one as each is taken
   task wr(input logic [7:0] a, input logic [31:0] d, input logic [1:0] e);
      logic pa, pw, ha, hw, hb;
      logic [1:0] r;
      s_axi_awaddr <= a;
      s_axi_wdata <= d;
      s_axi_awvalid <= 1'b1;
      s_axi_wvalid <= 1'b1;
      pa = 1'b1;
      pw = 1'b1;
      while (pa || pw)
      begin
         @(negedge clock_in);  // readys only move on the rising edge
         ha = pa && s_axi_awready;
         hw = pw && s_axi_wready;
         @(posedge clock_in);
         if (ha) s_axi_awvalid <= 1'b0;
         if (hw) s_axi_wvalid <= 1'b0;
         pa = pa && !ha;
         pw = pw && !hw;
      end
      s_axi_bready <= 1'b1;
      do
      begin
         @(negedge clock_in);
         hb = s_axi_bvalid;
         r = s_axi_bresp;
         @(posedge clock_in);
      end while (hb !== 1'b1);
      s_axi_bready <= 1'b0;
      check(32'(r), 32'(e), "write response");
   endtask : wr
   // bus read: masked data and response compared
   task rd(input logic [7:0] a, input logic [31:0] m, input logic [31:0] x,
           input logic [1:0] e);
      logic h;
      logic [31:0] d;
      logic [1:0] r;
      s_axi_araddr <= a;
      s_axi_arvalid <= 1'b1;
      do
      begin
         @(negedge clock_in);
         h = s_axi_arready;
         @(posedge clock_in);
      end while (h !== 1'b1);
      s_axi_arvalid <= 1'b0;
      s_axi_rready <= 1'b1;
      do
      begin
         @(negedge clock_in);
         h = s_axi_rvalid;
         d = s_axi_rdata;
         r = s_axi_rresp;
         @(posedge clock_in);
      end while (h !== 1'b1);
      s_axi_rready <= 1'b0;
      check(d & m, x, "read data");
      check(32'(r), 32'(e), "read response");
   endtask : rd
   task drive(input logic v, input int len);
      comp_in <= v;
      repeat (len) @(posedge clock_in);
   endtask : drive
   // requests since the last call, read once counters have settled
   task pulses(input int en, input int ei);
      @(negedge clock_in);
      check(n_nmi - b_n, en, "nmi count");
      check(n_irq - b_i, ei, "irq count");
      b_n = n_nmi;
      b_i = n_irq;
      @(posedge clock_in);
   endtask : pulses
   task wrap_up;
      if (n_errors == 0 && n_tests > 0)
         $display("bench passed");
      else
         $display("bench failed");
      $finish;
   endtask : wrap_up
   // ----------------------------------------------------------
   // main sequence
   // ----------------------------------------------------------
   initial
   begin
      {rst_b_in, s_axi_awvalid, s_axi_wvalid, s_axi_bready} = 4'h0;
      {s_axi_arvalid, s_axi_rready, s_axi_awaddr, s_axi_araddr} = 18'h0;
      s_axi_wdata = 32'h0;
      s_axi_wstrb = 4'hf;
      comp_in = 1'b1;
      repeat (8) @(posedge clock_in);
      rst_b_in <= 1'b1;
      @(negedge clock_in);
      check(32'({level_select_one_out, detect_enable_out}), 32'h0, "rst out");
      @(posedge clock_in);
      rd(LV, 32'hf, 32'h0, OK);
      rd(CE, 32'h1, 32'h0, OK);
      rd(CA, 32'h7f, 32'h02, OK);
      rd(CB, 32'h7, 32'h1, OK);
      rd(ST, 32'h1, 32'h0, OK);
      rd(8'h14, 32'h0, 32'h0, ERR);
      wr(8'h14, 32'h1, ERR);
      // enable in interrupt mode, filter left off
      wr(LV, 32'ha, OK);
      wr(CE, 32'h1, OK);
      @(negedge clock_in);
      check(32'({level_select_one_out, detect_enable_out}),
            32'h15, "ctl");
      repeat (20) @(posedge clock_in);  // settle time
      wr(CA, 32'h06, OK);
      repeat (40) @(posedge clock_in);  // 2 us, no filter
      wr(ST, 32'h0, OK);
      wr(CA, 32'h07, OK);
      // every edge code with both request kinds
      for (int e = 0; e < 4; e++)
         for (int n = 0; n < 2; n++)
         begin
            wr(CB, {29'h0, n[0], e[1:0]}, OK);
            drive(1'b0, 20);
            wr(ST, 32'h0, OK);
            drive(1'b1, 20);
            wr(ST, 32'h0, OK);
            pulses(n ? EXP[e] : 0, n ? 0 : EXP[e]);
         end
      // comparison output gated: falling edge selected so it could trip
      wr(CB, 32'h1, OK);
      wr(CA, 32'h03, OK);
      drive(1'b0, 20);
      drive(1'b1, 20);
      pulses(0, 0);
      rd(ST, 32'h1, 32'h0, OK);
      // flag, monitor and clearing
      wr(CA, 32'h07, OK);
      drive(1'b0, 20);
      pulses(0, 1);
      rd(ST, 32'h3, 32'h1, OK);
      wr(ST, 32'h1, OK);
      rd(ST, 32'h1, 32'h1, OK);
      wr(ST, 32'h0, OK);
      rd(ST, 32'h1, 32'h0, OK);
      drive(1'b1, 20);
      rd(ST, 32'h2, 32'h2, OK);
      wr(ST, 32'h0, OK);
      drive(1'b0, 3);
      drive(1'b1, 20);
      pulses(0, 1);
      wr(ST, 32'h0, OK);
      // filter with n = 2, then n = 16
      wr(CA, 32'h05, OK);
      repeat (7 * DIV) @(posedge clock_in);  // 2n+3 osc cycles
      drive(1'b0, 3);
      drive(1'b1, 40);
      pulses(0, 0);
      drive(1'b0, 40);
      drive(1'b1, 60);
      pulses(0, 1);
      wr(ST, 32'h0, OK);
      wr(CA, 32'h65, OK);
      repeat (35 * DIV) @(posedge clock_in);  // 2n+3 osc cycles
      drive(1'b0, 40);
      drive(1'b1, 300);
      pulses(0, 0);
      drive(1'b0, 300);
      drive(1'b1, 300);
      pulses(0, 1);
      // reset mode, negation held until the supply is back
      wr(CA, 32'h0e, OK);
      wr(ST, 32'h0, OK);
      wr(CA, 32'h0f, OK);
      drive(1'b0, 20);
      @(negedge clock_in);
      check(32'({monitor_reset_out, reset_negation_type_out}),
            32'h2, "rst");
      @(posedge clock_in);
      drive(1'b1, 20);
      @(negedge clock_in);
      check(32'(monitor_reset_out), 32'h0, "reset release");
      @(posedge clock_in);
      wr(CA, 32'h1f, OK);
      @(negedge clock_in);
      check(32'(reset_negation_type_out), 32'h1, "negation type");
      pulses(0, 0);
      // disable sequence with the filter in use
      wr(CA, 32'h05, OK);
      wr(ST, 32'h0, OK);
      wr(CA, 32'h01, OK);
      repeat (7 * DIV) @(posedge clock_in);  // 2n+3 osc cycles
      wr(CA, 32'h00, OK);
      wr(CA, 32'h02, OK);
      wr(CE, 32'h0, OK);
      drive(1'b0, 40);
      drive(1'b1, 40);
      pulses(0, 0);
      check(32'(detect_enable_out), 32'h0, "circuit disabled");
      // all off: other configuration may now change
      wr(LV, 32'h5, OK);
      rd(LV, 32'hf, 32'h5, OK);
      wrap_up;
   end
   // the run needs a few thousand cycles; 30000 means a hang
   initial
   begin
      #(30000 * 50);
      n_errors++;
      wrap_up;
   end
endmodule : tb_vmon_top
